// ---- host_bus_master.sv ----
`timescale 1ns/1ps
module host_bus_master
#(
    parameter int HALF_NS = 625,
    parameter int GAP_NS  = 500000
)
(
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_low_out,
    output logic      sda_low_out
);
    initial
    begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end

    task automatic release_scl;
        int n;
        scl_low_out = 1'b0;
        n = 0;
        while (!scl_in && n < 1000)
        begin
            #10;
            n++;
        end
        #(HALF_NS);
    endtask

    // Data changes only in mid low phase, so it is never read as a start or stop.
    task automatic bit_io(input logic b, output logic r);
        #(HALF_NS / 2);
        sda_low_out = !b;
        #(HALF_NS / 2);
        release_scl();
        r = sda_in;
        scl_low_out = 1'b1;
    endtask

    task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r[i]);
        bit_io(1'b1, ack);
    endtask

    task automatic session(input logic [7:0] hdr, input logic [7:0] d, output logic a_ack, output logic [7:0] r);
        logic [7:0] junk;
        logic       d_ack;
        sda_low_out = 1'b1;
        #(HALF_NS);
        scl_low_out = 1'b1;
        xfer(hdr, junk, a_ack);
        r = 8'h00;
        if (!a_ack)
            xfer(hdr[0] ? 8'hff : d, r, d_ack);
        #(HALF_NS / 2);
        sda_low_out = 1'b1;
        #(HALF_NS / 2);
        release_scl();
        sda_low_out = 1'b0;
        #(HALF_NS);
        if (a_ack)
            #(GAP_NS);
    endtask
endmodule

// ---- host_smbus_slave_port.sv ----
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module host_smbus_slave_port
    import hsp_pkg::*;
(
    // Core clock, reset and enable.
    input  wire logic       CLK_IN,
    input  wire logic       RST_IN,
    input  wire logic       CE_IN,
    // Link clock domain.
    input  wire logic       LINK_CLK_IN,
    input  wire logic       LINK_RST_IN,
    // Register port.
    input  wire logic [7:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    output logic      [7:0] REG_RDATA_OUT,
    // Power state.
    input  wire logic       MAIN_POWER_GOOD_IN,
    // Host bus pins.
    input  wire logic       HOST_BUS_CLOCK_PIN_IN,
    output logic            HOST_BUS_CLOCK_PIN_OUT,
    output logic            HOST_BUS_CLOCK_PIN_OE_N_OUT,
    input  wire logic       HOST_BUS_DATA_PIN_IN,
    output logic            HOST_BUS_DATA_PIN_OUT,
    output logic            HOST_BUS_DATA_PIN_OE_N_OUT,
    output logic            HOST_ALERT_PIN_OUT,
    output logic            HOST_ALERT_PIN_OE_N_OUT
);
    logic [7:0]  iso_ctrl_reg;
    logic [6:0]  target_addr_reg;
    logic [1:0]  chan_ctrl_reg;
    logic [7:0]  resp_data_reg;
    logic        resp_tgl_reg;
    logic        rx_seen_tgl_reg;
    logic        nacked_reg;
    logic [7:0]  req_data_reg;
    logic        req_avail_reg;
    logic        alert_reg;
    logic        pg_sync;
    bus_pins_t   pins_raw;
    bus_pins_t   pins;
    logic [5:0]  to_link;
    logic [5:0]  to_link_s;
    logic [2:0]  to_core_s;

    // Link-domain state.
    link_state_t state_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic        rw_reg;
    logic        scl_d_reg;
    logic        sda_d_reg;
    logic        sda_low_reg;
    logic        stretch_reg;
    logic        rx_tgl_reg;
    logic        nack_tgl_reg;
    logic        taken_tgl_reg;
    logic [7:0]  rx_byte_reg;
    logic        resp_seen_reg;
    logic        tx_pending_reg;

    logic [2:0]  core_tgl_d_reg;
    logic        isolate;
    logic        start_cond;
    logic        stop_cond;
    logic        scl_rise;
    logic        scl_fall;
    logic        ready_l;
    logic        resp_new_l;

    hsp_sync #(.WIDTH(1)) u_pg_sync
    (
        .clk_in (CLK_IN),
        .rst_in (RST_IN),
        .d_in   (MAIN_POWER_GOOD_IN),
        .q_out  (pg_sync)
    );

    assign to_link = {resp_tgl_reg, chan_ctrl_reg, 1'b0, target_addr_reg[0], 1'b0};

    hsp_sync #(.WIDTH(6)) u_to_link
    (
        .clk_in (LINK_CLK_IN),
        .rst_in (LINK_RST_IN),
        .d_in   (to_link),
        .q_out  (to_link_s)
    );

    hsp_sync #(.WIDTH(3)) u_to_core
    (
        .clk_in (CLK_IN),
        .rst_in (RST_IN),
        .d_in   ({taken_tgl_reg, nack_tgl_reg, rx_tgl_reg}),
        .q_out  (to_core_s)
    );

    assign pins_raw = '{scl: HOST_BUS_CLOCK_PIN_IN, sda: HOST_BUS_DATA_PIN_IN};

    hsp_sync #(.WIDTH(2)) u_pin_sync
    (
        .clk_in (LINK_CLK_IN),
        .rst_in (LINK_RST_IN),
        .d_in   (pins_raw),
        .q_out  (pins)
    );

    // Register file; set by hardware wins over clear by software.
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            iso_ctrl_reg    <= ISOLATION_CONTROL_RESET;
            target_addr_reg <= TARGET_ADDRESS_RESET;
            chan_ctrl_reg   <= 2'h0;
            resp_data_reg   <= 8'h00;
            resp_tgl_reg    <= 1'b0;
        end
        else if (CE_IN && REG_WR_IN)
        begin
            unique case (REG_ADDR_IN)
                ISOLATION_CONTROL_OFFSET: iso_ctrl_reg <= REG_WDATA_IN;
                CHANNEL_CONTROL_OFFSET:   chan_ctrl_reg <= REG_WDATA_IN[1:0];
                TARGET_ADDRESS_OFFSET:    target_addr_reg <= REG_WDATA_IN[6:0];
                RESPONSE_DATA_OFFSET:
                begin
                    resp_data_reg <= REG_WDATA_IN;
                    resp_tgl_reg  <= ~resp_tgl_reg;
                end
                default:
                begin
                end
            endcase
        end
    end

    // Core-side events from the link.
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            core_tgl_d_reg <= 3'h0;
            req_avail_reg  <= 1'b0;
            req_data_reg   <= 8'h00;
            nacked_reg     <= 1'b0;
            alert_reg      <= 1'b0;
        end
        else if (CE_IN)
        begin
            core_tgl_d_reg <= to_core_s;
            if (to_core_s[0] != core_tgl_d_reg[0])
            begin
                req_avail_reg <= 1'b1;
                req_data_reg  <= rx_byte_reg;
            end
            else if (REG_RD_IN && REG_ADDR_IN == REQUEST_DATA_OFFSET)
                req_avail_reg <= 1'b0;
            if (to_core_s[1] != core_tgl_d_reg[1])
                nacked_reg <= 1'b1;
            else if (REG_RD_IN && REG_ADDR_IN == PORT_STATUS_OFFSET)
                nacked_reg <= 1'b0;
            if (REG_WR_IN && REG_ADDR_IN == RESPONSE_DATA_OFFSET)
                alert_reg <= 1'b1;
            else if (to_core_s[2] != core_tgl_d_reg[2])
                alert_reg <= 1'b0;
        end
    end

    // Read data one cycle after the strobe.
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            REG_RDATA_OUT <= 8'h00;
        else if (CE_IN)
        begin
            REG_RDATA_OUT <= 8'h00;
            if (REG_RD_IN)
            begin
                unique case (REG_ADDR_IN)
                    ISOLATION_CONTROL_OFFSET: REG_RDATA_OUT <= iso_ctrl_reg;
                    PORT_STATUS_OFFSET:
                        REG_RDATA_OUT <= {4'h0, nacked_reg, isolate, alert_reg, req_avail_reg};
                    CHANNEL_CONTROL_OFFSET:   REG_RDATA_OUT <= {2'h0, HOST_CHANNEL, chan_ctrl_reg};
                    RESPONSE_DATA_OFFSET:     REG_RDATA_OUT <= resp_data_reg;
                    REQUEST_DATA_OFFSET:      REG_RDATA_OUT <= req_data_reg;
                    TARGET_ADDRESS_OFFSET:    REG_RDATA_OUT <= {1'b0, target_addr_reg};
                    default:                  REG_RDATA_OUT <= 8'h00;
                endcase
            end
        end
    end

    assign isolate = ~pg_sync & ~iso_ctrl_reg[ISO_DISABLE_BIT];

    // Link side: address, byte receive and response byte transmit.
    assign start_cond = scl_d_reg & pins.scl & sda_d_reg & ~pins.sda;
    assign stop_cond  = scl_d_reg & pins.scl & ~sda_d_reg & pins.sda;
    assign scl_rise   = ~scl_d_reg & pins.scl;
    assign scl_fall   = scl_d_reg & ~pins.scl;
    assign resp_new_l = to_link_s[5] != resp_seen_reg;
    assign ready_l    = ~to_link_s[CHAN_BUSY_BIT + 3] & (to_link_s[CHAN_RESP_RDY_BIT + 3] | ~tx_pending_reg);

    always_ff @(posedge LINK_CLK_IN or posedge LINK_RST_IN)
    begin
        if (LINK_RST_IN)
        begin
            state_reg      <= ST_IDLE;
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 4'h0;
            rw_reg         <= 1'b0;
            scl_d_reg      <= 1'b1;
            sda_d_reg      <= 1'b1;
            sda_low_reg    <= 1'b0;
            stretch_reg    <= 1'b0;
            rx_tgl_reg     <= 1'b0;
            nack_tgl_reg   <= 1'b0;
            taken_tgl_reg  <= 1'b0;
            rx_byte_reg    <= 8'h00;
            resp_seen_reg  <= 1'b0;
            tx_pending_reg <= 1'b0;
        end
        else
        begin
            scl_d_reg <= pins.scl;
            sda_d_reg <= pins.sda;
            if (resp_new_l)
            begin
                resp_seen_reg  <= to_link_s[5];
                tx_pending_reg <= 1'b1;
            end
            // Hold the clock low after a byte until the core has caught up.
            stretch_reg <= (state_reg == ST_RACK || state_reg == ST_TACK) & ~pins.scl & to_link_s[CHAN_BUSY_BIT + 3];
            if (stop_cond)
            begin
                state_reg   <= ST_IDLE;
                sda_low_reg <= 1'b0;
            end
            else if (start_cond)
            begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_low_reg <= 1'b0;
            end
            else
            begin
                unique case (state_reg)
                    ST_IDLE:
                    begin
                    end
                    ST_ADDR, ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg   <= {shift_reg[6:0], pins.sda};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_reg == 4'h8)
                        begin
                            bit_cnt_reg <= 4'h0;
                            if (state_reg == ST_ADDR)
                            begin
                                rw_reg <= shift_reg[0];
                                if (shift_reg[7:1] != target_addr_reg)
                                    state_reg <= ST_IDLE;
                                else if (!ready_l || (shift_reg[0] && !(tx_pending_reg && to_link_s[CHAN_RESP_RDY_BIT + 3])))
                                begin
                                    nack_tgl_reg <= ~nack_tgl_reg;
                                    state_reg    <= ST_IDLE;
                                end
                                else
                                begin
                                    sda_low_reg <= 1'b1;
                                    state_reg   <= ST_AACK;
                                end
                            end
                            else
                            begin
                                rx_byte_reg <= shift_reg;
                                rx_tgl_reg  <= ~rx_tgl_reg;
                                sda_low_reg <= 1'b1;
                                state_reg   <= ST_RACK;
                            end
                        end
                    end
                    ST_AACK, ST_RACK:
                    begin
                        if (scl_fall)
                        begin
                            if (rw_reg)
                            begin
                                shift_reg   <= resp_data_reg;
                                sda_low_reg <= ~resp_data_reg[7];
                                state_reg   <= ST_TX;
                            end
                            else
                            begin
                                sda_low_reg <= 1'b0;
                                state_reg   <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            shift_reg   <= {shift_reg[6:0], 1'b1};
                            sda_low_reg <= (bit_cnt_reg == 4'h7) ? 1'b0 : ~shift_reg[6];
                            if (bit_cnt_reg == 4'h7)
                            begin
                                bit_cnt_reg    <= 4'h0;
                                taken_tgl_reg  <= ~taken_tgl_reg;
                                tx_pending_reg <= 1'b0;
                                state_reg      <= ST_TACK;
                            end
                        end
                    end
                    ST_TACK:
                    begin
                        if (scl_rise)
                            state_reg <= pins.sda ? ST_IDLE : ST_TACK;
                        else if (scl_fall)
                        begin
                            shift_reg   <= resp_data_reg;
                            sda_low_reg <= ~resp_data_reg[7];
                            state_reg   <= ST_TX;
                        end
                    end
                    default:
                        state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Open-drain pins: enable low drives a zero; isolation floats all of them.
    assign HOST_BUS_CLOCK_PIN_OUT      = 1'b0;
    assign HOST_BUS_DATA_PIN_OUT       = 1'b0;
    assign HOST_ALERT_PIN_OUT          = 1'b0;
    assign HOST_BUS_CLOCK_PIN_OE_N_OUT = ~(stretch_reg & ~isolate);
    assign HOST_BUS_DATA_PIN_OE_N_OUT  = ~(sda_low_reg & ~isolate);
    assign HOST_ALERT_PIN_OE_N_OUT     = ~(alert_reg & ~isolate);
endmodule

// ---- hsp_asserts.sv ----
`timescale 1ns/1ps
module hsp_asserts
    import hsp_pkg::*;
(
    input  wire logic       CLK_IN,
    input  wire logic       RST_IN,
    input  wire logic       CE_IN,
    input  wire logic [7:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    input  wire logic [7:0] REG_RDATA_OUT,
    input  wire logic       MAIN_POWER_GOOD_IN,
    input  wire logic       HOST_BUS_CLOCK_PIN_IN,
    input  wire logic       HOST_BUS_CLOCK_PIN_OE_N_OUT,
    input  wire logic       HOST_BUS_DATA_PIN_OE_N_OUT,
    input  wire logic       HOST_ALERT_PIN_OE_N_OUT
);
    logic [7:0] iso_reg;
    logic [6:0] float_cnt;
    logic [7:0] quiet_cnt;
    logic       rd_ok;

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    assign rd_ok = REG_RD_IN && CE_IN;

    always_ff @(posedge CLK_IN or posedge RST_IN)
        if (RST_IN)
            iso_reg <= ISOLATION_CONTROL_RESET;
        else if (REG_WR_IN && CE_IN && REG_ADDR_IN == ISOLATION_CONTROL_OFFSET)
            iso_reg <= REG_WDATA_IN;

    // Counts how long the pins have been owed isolation, covering the sync delay.
    always_ff @(posedge CLK_IN or posedge RST_IN)
        if (RST_IN)
            float_cnt <= 7'h00;
        else if (MAIN_POWER_GOOD_IN || iso_reg[ISO_DISABLE_BIT])
            float_cnt <= 7'h00;
        else if (float_cnt != 7'h7f)
            float_cnt <= float_cnt + 7'h01;

    // Counts cycles of an idle host clock line that is powered or has isolation disabled.
    always_ff @(posedge CLK_IN or posedge RST_IN)
        if (RST_IN)
            quiet_cnt <= 8'h00;
        else if (!HOST_BUS_CLOCK_PIN_IN || !(MAIN_POWER_GOOD_IN || iso_reg[ISO_DISABLE_BIT]))
            quiet_cnt <= 8'h00;
        else if (quiet_cnt != 8'hff)
            quiet_cnt <= quiet_cnt + 8'h01;

    chk_iso_floats: assert property (float_cnt > 7'h64 |->
        HOST_BUS_CLOCK_PIN_OE_N_OUT && HOST_BUS_DATA_PIN_OE_N_OUT && HOST_ALERT_PIN_OE_N_OUT)
        else $error("host pins driven while isolated");
    chk_iso_readback: assert property (rd_ok && REG_ADDR_IN == ISOLATION_CONTROL_OFFSET |=>
        REG_RDATA_OUT == $past(iso_reg))
        else $error("isolation control read back wrong");
    chk_chan_number: assert property (rd_ok && REG_ADDR_IN == CHANNEL_CONTROL_OFFSET |=>
        REG_RDATA_OUT[5:2] == HOST_CHANNEL)
        else $error("host channel number wrong");
    chk_stretch_low: assert property ($fell(HOST_BUS_CLOCK_PIN_OE_N_OUT) |->
        !$past(HOST_BUS_CLOCK_PIN_IN))
        else $error("clock pulled low during a high phase");
    chk_alert_holds: assert property (!HOST_ALERT_PIN_OE_N_OUT && quiet_cnt == 8'hff
        && !(REG_WR_IN && CE_IN && REG_ADDR_IN == ISOLATION_CONTROL_OFFSET) |=> !HOST_ALERT_PIN_OE_N_OUT)
        else $error("alert dropped with no transfer");
    chk_alert_armed: assert property (REG_WR_IN && CE_IN && REG_ADDR_IN == RESPONSE_DATA_OFFSET
        && quiet_cnt == 8'hff |-> ##[1:100] !HOST_ALERT_PIN_OE_N_OUT)
        else $error("alert not raised for waiting response");
    chk_idle_data: assert property (quiet_cnt == 8'hff |-> HOST_BUS_DATA_PIN_OE_N_OUT)
        else $error("data driven on an idle bus");
    chk_reset_release: assert property ($fell(RST_IN) |-> HOST_BUS_CLOCK_PIN_OE_N_OUT
        && HOST_BUS_DATA_PIN_OE_N_OUT && HOST_ALERT_PIN_OE_N_OUT)
        else $error("pins not released out of reset");
endmodule

bind host_smbus_slave_port hsp_asserts u_hsp_asserts (
    .CLK_IN                      (CLK_IN),
    .RST_IN                      (RST_IN),
    .CE_IN                       (CE_IN),
    .REG_ADDR_IN                 (REG_ADDR_IN),
    .REG_WDATA_IN                (REG_WDATA_IN),
    .REG_WR_IN                   (REG_WR_IN),
    .REG_RD_IN                   (REG_RD_IN),
    .REG_RDATA_OUT               (REG_RDATA_OUT),
    .MAIN_POWER_GOOD_IN          (MAIN_POWER_GOOD_IN),
    .HOST_BUS_CLOCK_PIN_IN       (HOST_BUS_CLOCK_PIN_IN),
    .HOST_BUS_CLOCK_PIN_OE_N_OUT (HOST_BUS_CLOCK_PIN_OE_N_OUT),
    .HOST_BUS_DATA_PIN_OE_N_OUT  (HOST_BUS_DATA_PIN_OE_N_OUT),
    .HOST_ALERT_PIN_OE_N_OUT     (HOST_ALERT_PIN_OE_N_OUT)
);

// ---- hsp_pkg.sv ----
package hsp_pkg;

    // Register map, byte offsets on the plain register port.
    localparam logic [7:0] ISOLATION_CONTROL_OFFSET = 8'h05;
    localparam logic [7:0] PORT_STATUS_OFFSET       = 8'h06;
    localparam logic [7:0] CHANNEL_CONTROL_OFFSET   = 8'h07;
    localparam logic [7:0] RESPONSE_DATA_OFFSET     = 8'h08;
    localparam logic [7:0] REQUEST_DATA_OFFSET      = 8'h09;
    localparam logic [7:0] TARGET_ADDRESS_OFFSET    = 8'h0a;

    // Field positions.
    localparam int ISO_DISABLE_BIT   = 0;
    localparam int CHAN_BUSY_BIT     = 0;
    localparam int CHAN_RESP_RDY_BIT = 1;
    localparam int STAT_REQ_AVAIL    = 0;
    localparam int STAT_ALERT        = 1;
    localparam int STAT_ISOLATED     = 2;
    localparam int STAT_NACKED       = 3;

    // Reset values.
    localparam logic [7:0] ISOLATION_CONTROL_RESET = 8'h00;
    localparam logic [6:0] TARGET_ADDRESS_RESET    = 7'h20;

    // Channel numbers.
    localparam logic [3:0] LAN_CHANNEL  = 4'h1;
    localparam logic [3:0] HOST_CHANNEL = 4'h2;

    // Host spacing between sessions after a refusal.
    localparam int SESSION_GAP_US = 500;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_AACK = 7'b0000100,
        ST_RX   = 7'b0001000,
        ST_RACK = 7'b0010000,
        ST_TX   = 7'b0100000,
        ST_TACK = 7'b1000000
    } link_state_t;

endpackage

// ---- hsp_sync.sv ----
`timescale 1ns/1ps
module hsp_sync
    import hsp_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_reg <= '0;
            q_out    <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import hsp_pkg::*;

    logic       clk;
    logic       rst;
    logic       link_clk;
    logic       link_rst;
    logic       pg;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr;
    logic       rd;
    logic       scl;
    logic       sda;
    logic       scl_oe_n;
    logic       sda_oe_n;
    logic       alert_oe_n;
    logic       m_scl_low;
    logic       m_sda_low;
    int         num_errors;
    int         compares;

    assign scl = !(m_scl_low || !scl_oe_n);
    assign sda = !(m_sda_low || !sda_oe_n);

    host_smbus_slave_port u_host_smbus_slave_port (
        .CLK_IN                      (clk),
        .RST_IN                      (rst),
        .CE_IN                       (1'b1),
        .LINK_CLK_IN                 (link_clk),
        .LINK_RST_IN                 (link_rst),
        .REG_ADDR_IN                 (addr),
        .REG_WDATA_IN                (wdata),
        .REG_WR_IN                   (wr),
        .REG_RD_IN                   (rd),
        .REG_RDATA_OUT               (rdata),
        .MAIN_POWER_GOOD_IN          (pg),
        .HOST_BUS_CLOCK_PIN_IN       (scl),
        .HOST_BUS_CLOCK_PIN_OUT      (),
        .HOST_BUS_CLOCK_PIN_OE_N_OUT (scl_oe_n),
        .HOST_BUS_DATA_PIN_IN        (sda),
        .HOST_BUS_DATA_PIN_OUT       (),
        .HOST_BUS_DATA_PIN_OE_N_OUT  (sda_oe_n),
        .HOST_ALERT_PIN_OUT          (),
        .HOST_ALERT_PIN_OE_N_OUT     (alert_oe_n)
    );

    // The host's back-off gap is shortened to keep the run brief.
    host_bus_master #(.GAP_NS(20000)) u_host_bus_master (
        .scl_in      (scl),
        .sda_in      (sda),
        .scl_low_out (m_scl_low),
        .sda_low_out (m_sda_low)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        link_clk = 1'b0;
        #37;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic close_out;
        if (num_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & mask, exp);
    endtask

    task automatic wait_alert(input logic exp);
        int n;
        n = 0;
        while (alert_oe_n !== exp && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 300)
        begin
            num_errors++;
            close_out();
        end
        chk({7'h00, alert_oe_n}, {7'h00, exp});
    endtask

    task automatic sess(input logic [7:0] h, input logic [7:0] d, input logic ea, input logic [7:0] er);
        logic       a;
        logic [7:0] r;
        u_host_bus_master.session(h, d, a, r);
        chk({7'h00, a}, {7'h00, ea});
        if (h[0] && !ea)
            chk(r, er);
    endtask

    initial
    begin
        #700000;
        num_errors++;
        close_out();
    end

    initial
    begin
        num_errors = 0;
        compares = 0;
        rst = 1'b1;
        link_rst = 1'b1;
        pg = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (2) @(posedge link_clk);
        link_rst <= 1'b0;
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(ISOLATION_CONTROL_OFFSET, 8'hff, ISOLATION_CONTROL_RESET);
        rd_chk(TARGET_ADDRESS_OFFSET, 8'h7f, 8'h20);
        rd_chk(CHANNEL_CONTROL_OFFSET, 8'h3c, {2'b00, HOST_CHANNEL, 2'b00});
        rd_chk(8'h3c, 8'hff, 8'h00);
        sess(8'h40, 8'h11, 1'b1, 8'h00);
        rd_chk(PORT_STATUS_OFFSET, 8'h04, 8'h04);
        reg_wr(ISOLATION_CONTROL_OFFSET, 8'h01);
        rd_chk(ISOLATION_CONTROL_OFFSET, 8'hff, 8'h01);
        sess(8'h40, 8'h5a, 1'b0, 8'h00);
        rd_chk(PORT_STATUS_OFFSET, 8'h01, 8'h01);
        rd_chk(REQUEST_DATA_OFFSET, 8'hff, 8'h5a);
        rd_chk(PORT_STATUS_OFFSET, 8'h01, 8'h00);
        sess(8'h41, 8'h00, 1'b1, 8'h00);
        rd_chk(PORT_STATUS_OFFSET, 8'h08, 8'h08);
        reg_wr(RESPONSE_DATA_OFFSET, 8'ha7);
        reg_wr(CHANNEL_CONTROL_OFFSET, 8'h02);
        wait_alert(1'b0);
        reg_wr(ISOLATION_CONTROL_OFFSET, 8'h00);
        wait_alert(1'b1);
        pg <= 1'b1;
        wait_alert(1'b0);
        sess(8'h41, 8'h00, 1'b0, 8'ha7);
        wait_alert(1'b1);
        reg_wr(CHANNEL_CONTROL_OFFSET, 8'h01);
        sess(8'h40, 8'h33, 1'b1, 8'h00);
        rd_chk(PORT_STATUS_OFFSET, 8'h08, 8'h08);
        reg_wr(CHANNEL_CONTROL_OFFSET, 8'h00);
        sess(8'h40, 8'h33, 1'b0, 8'h00);
        rd_chk(REQUEST_DATA_OFFSET, 8'hff, 8'h33);
        close_out();
    end
endmodule
